// File: pwss_top.v
`include "pwss_defs.vh"
`default_nettype none
module pwss_top #(
  parameter W = `PWSS_PERIOD_W
) (
  input  wire         sys_clk,
  input  wire         reset,
  input  wire         module_enable,
  input  wire [1:0]   output_polarity_field,
  input  wire [W-1:0] period_value,
  input  wire [W-1:0] duty_value,
  input  wire [3:0]   pin_output_enable,
  input  wire         auto_restart_enable,
  input  wire         shutdown_pin,
  input  wire         shutdown_wr,
  input  wire         shutdown_wr_data,
  input  wire         period_flag_clear,
  output reg          period_timer_flag,
  output reg          shutdown_event_status,
  output reg          pwm_out_a,
  output reg          pwm_out_b,
  output reg          pwm_out_c,
  output reg          pwm_out_d,
  output reg  [3:0]   pwm_oe_n
);
  ////////////////////////////////////////////////////////////////////
  wire         sd_cause;
  reg  [W-1:0] cnt_q;
  reg          first_q;
  reg          run_q;
  reg          halt_q;
  reg  [3:0]   oe_allow_q;
  wire         wrap;
  wire         raw_pwm;
  wire         on_ac;
  wire         on_bd;

  pwss_sync2 u_sd_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (shutdown_pin),
    .dout    (sd_cause)
  );

  assign wrap    = run_q && (cnt_q >= period_value);
  assign raw_pwm = run_q && (cnt_q < duty_value);
  // pair a/c active level by bit 1, pair b/d by bit 0
  assign on_ac = raw_pwm ^ output_polarity_field[`PWSS_POL_AC_BIT]; // [RL2]
  assign on_bd = raw_pwm ^ output_polarity_field[`PWSS_POL_BD_BIT]; // [RL2]

  ////////////////////////////////////////////////////////////////////
  // period timer and first-cycle tracking
  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_q             <= `PWSS_CNT_ZERO;
      run_q             <= 1'b0;
      first_q           <= 1'b0;
      period_timer_flag <= 1'b0;
    end else begin
      run_q <= module_enable;
      if (!module_enable) begin
        cnt_q   <= `PWSS_CNT_ZERO;
        first_q <= 1'b0;
      end else if (wrap) begin
        cnt_q   <= `PWSS_CNT_ZERO;
        first_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + `PWSS_CNT_ONE;
      end
      // set as each new period begins; set wins over clear
      if (wrap)
        period_timer_flag <= 1'b1; // [RL6]
      else if (period_flag_clear)
        period_timer_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // shutdown status and restart at period boundary
  always @(posedge sys_clk) begin
    if (reset) begin
      shutdown_event_status <= 1'b0;
      halt_q                <= 1'b0;
    end else begin
      if (sd_cause)
        shutdown_event_status <= 1'b1;
      else if (shutdown_wr && shutdown_wr_data)
        shutdown_event_status <= 1'b1; // [RL10]
      else if (auto_restart_enable)
        shutdown_event_status <= 1'b0; // [RL7]
      else if (shutdown_wr && !shutdown_wr_data)
        shutdown_event_status <= 1'b0; // [RL8] [RL9]
      // outputs stay parked until the next period start
      if (shutdown_event_status)
        halt_q <= 1'b1;
      else if (wrap || !run_q)
        halt_q <= 1'b0; // [RL8]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin enables: only once a full cycle has completed, so the
  // output latches hold valid levels before drivers turn on
  always @(posedge sys_clk) begin
    if (reset) begin
      oe_allow_q <= 4'h0; // [RL1]
      pwm_oe_n   <= 4'hf; // [RL1]
    end else begin
      if (!module_enable)
        oe_allow_q <= 4'h0;
      else if (first_q)
        oe_allow_q <= pin_output_enable; // [RL4] [RL5]
      else
        oe_allow_q <= 4'h0; // [RL4]
      pwm_oe_n <= ~oe_allow_q; // [RL1]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // in shutdown each pin drives its inactive level
  always @(posedge sys_clk) begin
    if (reset) begin
      pwm_out_a <= 1'b0;
      pwm_out_b <= 1'b0;
      pwm_out_c <= 1'b0;
      pwm_out_d <= 1'b0;
    end else if (halt_q || shutdown_event_status) begin
      pwm_out_a <= output_polarity_field[`PWSS_POL_AC_BIT]; // [RL10]
      pwm_out_c <= output_polarity_field[`PWSS_POL_AC_BIT];
      pwm_out_b <= output_polarity_field[`PWSS_POL_BD_BIT];
      pwm_out_d <= output_polarity_field[`PWSS_POL_BD_BIT];
    end else begin
      pwm_out_a <= on_ac;
      pwm_out_c <= on_ac;
      pwm_out_b <= on_bd;
      pwm_out_d <= on_bd;
    end
  end
endmodule // pwss_top
`default_nettype wire

// File: pwss_defs.vh
// Summary of operation
// [RL1] pins high-impedance after reset until enabled
// [RL2] two polarity bits: pair a/c, pair b/d
// [RL3] software sets polarity before enabling pins
// [RL4] drivers never enabled together with module
// [RL5] software waits one full cycle before pins
// [RL6] period flag set as second period begins
// [RL7] auto-restart: flag follows shutdown cause
// [RL8] no auto-restart: firmware clears, resume next period
// [RL9] clear ignored while shutdown cause active
// [RL10] software write one forces shutdown
`ifndef PWSS_DEFS_VH
`define PWSS_DEFS_VH
`define PWSS_POL_AC_BIT   1
`define PWSS_POL_BD_BIT   0
`define PWSS_PERIOD_W     8
`define PWSS_PERIOD_DEF   8'hff
`define PWSS_DUTY_DEF     8'h80
`define PWSS_CNT_ZERO     8'h00
`define PWSS_CNT_ONE      8'h01
`endif

// File: pwss_sync2.v
`default_nettype none
module pwss_sync2 (
  input  wire sys_clk,
  input  wire reset,
  input  wire din,
  output reg  dout
);
  reg meta_q;
  always @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // pwss_sync2
`default_nettype wire

// File: pwss_load.sv
`default_nettype none
// switch drivers: resistors hold each switch off while its pin floats
module pwss_load (
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe_n,
  output logic      [3:0] pin
);
  assign pin = (oe_n & 4'ha) | (~oe_n & drv);
endmodule // pwss_load
`default_nettype wire

// File: pwss_chk_checker.sv
`default_nettype none
module pwss_chk (
  input wire logic sys_clk, reset, module_enable, auto_restart_enable,
  input wire logic shutdown_pin, shutdown_wr, shutdown_wr_data,
  input wire logic period_timer_flag, shutdown_event_status,
  input wire logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d,
  input wire logic [3:0] pwm_oe_n,
  input wire logic [1:0] output_polarity_field
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_rst; $fell(reset) |-> &pwm_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("oe rst");
  property p_en; $rose(module_enable) |=> &pwm_oe_n [*2]; endproperty
  a_en: assert property (p_en) else $error("oe en");
  property p_fl; !module_enable [*2] |=> !$rose(period_timer_flag); endproperty
  a_fl: assert property (p_fl) else $error("flag");
  property p_ar; (auto_restart_enable && !shutdown_pin && !shutdown_wr) [*5]
    |-> !shutdown_event_status; endproperty
  a_ar: assert property (p_ar) else $error("restart");
  property p_hold; !auto_restart_enable && shutdown_event_status
    && !shutdown_wr |=> shutdown_event_status; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_blk; shutdown_pin [*4] ##0 shutdown_wr |=> shutdown_event_status;
  endproperty
  a_blk: assert property (p_blk) else $error("clear");
  property p_frc; shutdown_wr && shutdown_wr_data |=> shutdown_event_status;
  endproperty
  a_frc: assert property (p_frc) else $error("force");
  property p_off; shutdown_event_status |=> pwm_out_a == pwm_out_c
    && pwm_out_b == pwm_out_d && pwm_out_a == output_polarity_field[1]
    && pwm_out_b == output_polarity_field[0]; endproperty
  a_off: assert property (p_off) else $error("off");
endmodule // pwss_chk
bind pwss_top pwss_chk i_pwss_chk (.*);
`default_nettype wire

// File: pwss_top_test.sv
`default_nettype none
module pwss_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, reset = 1, module_enable = 0, shutdown_pin = 0;
  logic auto_restart_enable = 1, shutdown_wr = 0, shutdown_wr_data = 0;
  logic period_flag_clear = 0, period_timer_flag, shutdown_event_status;
  logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
  logic [1:0] output_polarity_field = 2'h2;
  logic [3:0] pin_output_enable = 4'h0, pwm_oe_n, pins;
  logic [7:0] period_value = 8'h07, duty_value = 8'h03;
  int num_errors = 0, check_count = 0, n, ca;
  always #12.5 sys_clk = ~sys_clk;
  pwss_top i_pwss_top (.*);
  pwss_load i_pwss_load (.drv({pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d}),
    .oe_n(pwm_oe_n), .pin(pins));
  task chk(input string s, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", s, e, g);
      num_errors++;
    end
  endtask
  task tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task wr(input logic v);
    {shutdown_wr, shutdown_wr_data} = {1'b1, v};
    tick(1);
    shutdown_wr = 0;
    tick(1);
  endtask
  task close_out;
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(16);
    reset = 0;
    tick(1);
    chk("rst", {pwm_oe_n, pins}, 8'hfa);
    // pins asked for with the enable: must stay off until the flag
    module_enable = 1;
    pin_output_enable = 4'hf;
    for (n = 0; n < 20 && period_timer_flag !== 1'b1; n++) tick(1);
    chk("flag", {period_timer_flag, pwm_oe_n}, 8'h1f);
    if (n == 20) close_out;
    period_flag_clear = 1;
    tick(1);
    period_flag_clear = 0;
    chk("fclr", period_timer_flag, 8'h00);
    tick(2);
    ca = 0;
    // duty 3 of 8 so a swapped polarity changes the count
    repeat (8) begin
      tick(1);
      ca += !pins[3] + pins[2];
    end
    chk("duty", {pwm_oe_n, ca[3:0]}, 8'h06);
    shutdown_pin = 1;
    tick(5);
    wr(0);
    chk("sd", {shutdown_event_status, pins[3]}, 8'h03);
    shutdown_pin = 0;
    tick(5);
    chk("ar", shutdown_event_status, 8'h00);
    auto_restart_enable = 0;
    wr(1);
    tick(8);
    chk("force", {shutdown_event_status, pins[3]}, 8'h03);
    wr(0);
    chk("clr", shutdown_event_status, 8'h00);
    // outputs come back at the next period start
    tick(10);
    ca = 0;
    repeat (8) begin
      tick(1);
      ca += !pins[3] + pins[2];
    end
    chk("resume", ca[7:0], 8'h06);
    close_out;
  end
endmodule // pwss_top_test
`default_nettype wire
